// ---- pin_condition_detect.sv ----
// one external channel's condition detector: level or edge on a pin.
// assumes the pin is already synchronous to the clock.
`default_nettype none

module pin_condition_detect (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic [1:0] cond,
   output logic hit
);

   logic pin_prev;

   // previous pin level for edge detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_prev <= 1'b0;
      end
      else
      begin
         pin_prev <= pin;
      end
   end

   // condition match on the current level, edges also against the previous level
   always_comb
   begin
      unique case (cond)
         request_routing_pkg::COND_LOW: hit = ~pin;
         request_routing_pkg::COND_HIGH: hit = pin;
         request_routing_pkg::COND_RISE: hit = pin & ~pin_prev;
         request_routing_pkg::COND_FALL: hit = ~pin & pin_prev;
      endcase
   end

endmodule

`default_nettype wire

// ---- request_router.sv ----
// peripheral request router: flags from external pins, calendar clock,
// tone generator and four timers, routed to interrupt lines and dma
// requests. assumes a single clock, source event inputs that are
// one-cycle pulses synchronous to MCLK, and a simple register port.
//
// The address-and-strobe port and the address map were left to the implementer.
`default_nettype none

// Behaviour
// R01: each external channel sets its own request flag when its chosen pin condition is seen.
// R02: channels 1 to 31 drive interrupt lines 70 to 100 in ascending order.
// R03: the calendar clock raises line 101 and its cause reads from bits 6..0 of its status.
// R04: the tone generator raises line 102 while any of its three flags is set.
// R05: timers 0 to 3 raise lines 104 to 107, each the OR of its wrap and zero flags.
// R06: dma requests 0 and 1 follow the external dma request pin.
// R07: the dma flag of channel n, n from 0 to 30, drives dma request 8 plus n.
// R08: the dma flag of channel 31 drives dma request 39.
// R09: the tone generator drives dma request 40 from its three flags.
// R10: interrupt line 103 and dma requests 2 to 7 stay inactive.
module request_router (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [31:0] EXT_PIN,
   input wire logic DMA_REQUEST_PIN,
   input wire logic [6:0] CAL_CAUSE_EVENT,
   input wire logic ZERO_AMPLITUDE_EVENT,
   input wire logic TONE_PULSE_COUNT_EVENT,
   input wire logic AMPLITUDE_MATCH_EVENT,
   input wire logic [3:0] TIMER_WRAP_EVENT,
   input wire logic [3:0] TIMER_ZERO_EVENT,
   output logic [107:70] IRQ_LINE,
   output logic [40:0] DMA_REQUEST,
   output logic IRQ
);

   // sticky flag update: a set in the same cycle beats the clear
   function automatic logic [31:0] sticky(
      input logic [31:0] old,
      input logic [31:0] set,
      input logic [31:0] clr
   );
      sticky = (old & ~clr) | set;
   endfunction

   // register select decode
   function automatic logic hits(
      input logic strobe,
      input logic [7:0] addr,
      input logic [7:0] offset
   );
      hits = strobe & (addr == offset);
   endfunction

   logic rst_q1;
   logic rst_n;
   logic [31:0] ext_irq_request_reg;
   logic [31:0] ext_enable;
   logic [31:0] ext_irq_dma_flag_reg;
   logic [31:0] ext_dma_enable;
   logic [31:0] ext_mode_lo;
   logic [31:0] ext_mode_hi;
   logic [6:0] clock_calendar_cause_status;
   logic [2:0] tone_gen_control;
   logic [7:0] free_timer_control_status;
   logic [3:0] evt_status;
   logic [3:0] evt_mask;
   logic [31:0] ext_hit;
   logic [31:0] ext_event;
   logic [31:0] ext_dma_event;
   logic [2:0] tone_event;
   logic [7:0] timer_event;
   logic [3:0] evt_event;
   logic [3:0] timer_line;
   logic [31:0] next_rdata;

   // reset release through two flops
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // per-channel condition detectors
   genvar ch;
   generate
      for (ch = 0; ch < request_routing_pkg::EXT_CHANNELS; ch++)
      begin : g_chan
         logic [1:0] cond;
         if (ch < 16)
         begin : g_lo
            assign cond = ext_mode_lo[2*ch +: 2];
         end
         else
         begin : g_hi
            assign cond = ext_mode_hi[2*(ch-16) +: 2];
         end
         pin_condition_detect u_detect (
            .clk(MCLK),
            .rst_n(rst_n),
            .pin(EXT_PIN[ch]),
            .cond(cond),
            .hit(ext_hit[ch])
         );
      end
   endgenerate

   // events from detectors, gated by channel and dma enables
   assign ext_event = ext_hit & ext_enable; // [R01]
   assign ext_dma_event = ext_hit & ext_dma_enable;

   // source event vectors
   assign tone_event = {AMPLITUDE_MATCH_EVENT, TONE_PULSE_COUNT_EVENT, ZERO_AMPLITUDE_EVENT};
   assign timer_event = {TIMER_ZERO_EVENT, TIMER_WRAP_EVENT};

   // summary events for the processor-side interrupt
   assign evt_event[request_routing_pkg::EVT_EXT_BIT] = |ext_event;
   assign evt_event[request_routing_pkg::EVT_CAL_BIT] = |CAL_CAUSE_EVENT;
   assign evt_event[request_routing_pkg::EVT_TONE_BIT] = |tone_event;
   assign evt_event[request_routing_pkg::EVT_TIMER_BIT] = |timer_event;

   // channel request flags, write one to clear
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_irq_request_reg <= request_routing_pkg::RST_ZERO;
      end
      else
      begin
         ext_irq_request_reg <= sticky(ext_irq_request_reg, ext_event, // [R01]
            hits(WR, ADDR, request_routing_pkg::OFF_EXT_REQUEST) ? WDATA : 32'h0000_0000);
      end
   end

   // channel dma flags, write one to clear
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_irq_dma_flag_reg <= request_routing_pkg::RST_ZERO;
      end
      else
      begin
         ext_irq_dma_flag_reg <= sticky(ext_irq_dma_flag_reg, ext_dma_event,
            hits(WR, ADDR, request_routing_pkg::OFF_EXT_DMA_FLAG) ? WDATA : 32'h0000_0000);
      end
   end

   // channel configuration registers
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_enable <= request_routing_pkg::RST_ZERO;
         ext_dma_enable <= request_routing_pkg::RST_ZERO;
         ext_mode_lo <= request_routing_pkg::RST_MODE;
         ext_mode_hi <= request_routing_pkg::RST_MODE;
      end
      else
      begin
         if (hits(WR, ADDR, request_routing_pkg::OFF_EXT_ENABLE))
         begin
            ext_enable <= WDATA;
         end
         if (hits(WR, ADDR, request_routing_pkg::OFF_EXT_DMA_ENABLE))
         begin
            ext_dma_enable <= WDATA;
         end
         if (hits(WR, ADDR, request_routing_pkg::OFF_EXT_MODE_LO))
         begin
            ext_mode_lo <= WDATA;
         end
         if (hits(WR, ADDR, request_routing_pkg::OFF_EXT_MODE_HI))
         begin
            ext_mode_hi <= WDATA;
         end
      end
   end

   // calendar cause flags, write one to clear
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clock_calendar_cause_status <= request_routing_pkg::RST_ZERO[6:0];
      end
      else
      begin
         clock_calendar_cause_status <= 7'(sticky(
            {25'h000_0000, clock_calendar_cause_status},
            {25'h000_0000, CAL_CAUSE_EVENT},
            hits(WR, ADDR, request_routing_pkg::OFF_CAL_CAUSE) ? WDATA : 32'h0000_0000)); // [R03]
      end
   end

   // tone generator flags, write one to clear
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tone_gen_control <= request_routing_pkg::RST_ZERO[2:0];
      end
      else
      begin
         tone_gen_control <= 3'(sticky(
            {29'h0000_0000, tone_gen_control},
            {29'h0000_0000, tone_event},
            hits(WR, ADDR, request_routing_pkg::OFF_TONE_CONTROL) ? WDATA : 32'h0000_0000));
      end
   end

   // timer wrap and zero flags, write one to clear
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         free_timer_control_status <= request_routing_pkg::RST_ZERO[7:0];
      end
      else
      begin
         free_timer_control_status <= 8'(sticky(
            {24'h00_0000, free_timer_control_status},
            {24'h00_0000, timer_event},
            hits(WR, ADDR, request_routing_pkg::OFF_TIMER_STATUS) ? WDATA : 32'h0000_0000));
      end
   end

   // summary status, cleared by a read, new events win
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_status <= request_routing_pkg::RST_ZERO[3:0];
      end
      else if (hits(RD, ADDR, request_routing_pkg::OFF_EVT_STATUS))
      begin
         evt_status <= evt_event;
      end
      else
      begin
         evt_status <= evt_status | evt_event;
      end
   end

   // summary mask
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_mask <= request_routing_pkg::RST_ZERO[3:0];
      end
      else if (hits(WR, ADDR, request_routing_pkg::OFF_EVT_MASK))
      begin
         evt_mask <= WDATA[3:0];
      end
   end

   // summary interrupt, high while an unmasked status bit is set
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         IRQ <= 1'b0;
      end
      else
      begin
         IRQ <= |(evt_status & evt_mask);
      end
   end

   // read data mux, unmapped reads give zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (RD)
      begin
         unique case (ADDR)
            request_routing_pkg::OFF_EXT_REQUEST: next_rdata = ext_irq_request_reg;
            request_routing_pkg::OFF_EXT_ENABLE: next_rdata = ext_enable;
            request_routing_pkg::OFF_EXT_DMA_FLAG: next_rdata = ext_irq_dma_flag_reg;
            request_routing_pkg::OFF_EXT_DMA_ENABLE: next_rdata = ext_dma_enable;
            request_routing_pkg::OFF_EXT_MODE_LO: next_rdata = ext_mode_lo;
            request_routing_pkg::OFF_EXT_MODE_HI: next_rdata = ext_mode_hi;
            request_routing_pkg::OFF_CAL_CAUSE:
               next_rdata = {25'h000_0000, clock_calendar_cause_status}; // [R03]
            request_routing_pkg::OFF_TONE_CONTROL:
               next_rdata = {29'h0000_0000, tone_gen_control};
            request_routing_pkg::OFF_TIMER_STATUS:
               next_rdata = {24'h00_0000, free_timer_control_status};
            request_routing_pkg::OFF_EVT_STATUS: next_rdata = {28'h000_0000, evt_status};
            request_routing_pkg::OFF_EVT_MASK: next_rdata = {28'h000_0000, evt_mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // read data register, valid the cycle after the strobe
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RDATA <= request_routing_pkg::RST_ZERO;
      end
      else
      begin
         RDATA <= next_rdata;
      end
   end

   // per-timer line: wrap or zero detect
   genvar t;
   generate
      for (t = 0; t < request_routing_pkg::TIMERS; t++)
      begin : g_timer
         assign timer_line[t] = free_timer_control_status[request_routing_pkg::TIMER_WRAP_LSB + t]
            | free_timer_control_status[request_routing_pkg::TIMER_ZERO_LSB + t]; // [R05]
      end
   endgenerate

   // interrupt lines toward the processor
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         IRQ_LINE <= '0;
      end
      else
      begin
         IRQ_LINE[100:70] <= ext_irq_request_reg[31:1]; // [R02]
         IRQ_LINE[request_routing_pkg::IRQ_CAL] <= |clock_calendar_cause_status; // [R03]
         IRQ_LINE[request_routing_pkg::IRQ_TONE] <= |tone_gen_control; // [R04]
         IRQ_LINE[request_routing_pkg::IRQ_UNUSED] <= 1'b0; // [R10]
         IRQ_LINE[107:104] <= timer_line; // [R05]
      end
   end

   // dma requests toward the dma controller
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         DMA_REQUEST <= '0;
      end
      else
      begin
         DMA_REQUEST[request_routing_pkg::DMA_PIN_REQ0] <= DMA_REQUEST_PIN; // [R06]
         DMA_REQUEST[request_routing_pkg::DMA_PIN_REQ1] <= DMA_REQUEST_PIN; // [R06]
         DMA_REQUEST[7:2] <= 6'h00; // [R10]
         DMA_REQUEST[38:8] <= ext_irq_dma_flag_reg[30:0]; // [R07]
         DMA_REQUEST[39] <= ext_irq_dma_flag_reg[31]; // [R08]
         DMA_REQUEST[request_routing_pkg::DMA_TONE] <= |tone_gen_control; // [R09]
      end
   end

endmodule

`default_nettype wire

// ---- request_router_monitor.sv ----
// checker for the request router, watching top-level ports only.
// assumes one clock domain and the read-data timing of the register port.
`default_nettype none

module request_router_monitor (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic DMA_REQUEST_PIN,
   input wire logic [6:0] CAL_CAUSE_EVENT,
   input wire logic ZERO_AMPLITUDE_EVENT,
   input wire logic TONE_PULSE_COUNT_EVENT,
   input wire logic AMPLITUDE_MATCH_EVENT,
   input wire logic [3:0] TIMER_WRAP_EVENT,
   input wire logic [3:0] TIMER_ZERO_EVENT,
   input wire logic [107:70] IRQ_LINE,
   input wire logic [40:0] DMA_REQUEST,
   input wire logic IRQ
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   logic [2:0] up_cnt;
   logic ready;
   logic tone_ev;
   logic [3:0] timer_ev;
   // cycles since reset release, so the internal reset copy has let go
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h4)
         up_cnt <= up_cnt + 3'h1;
   end
   assign ready = (up_cnt == 3'h4);
   assign tone_ev = ZERO_AMPLITUDE_EVENT | TONE_PULSE_COUNT_EVENT | AMPLITUDE_MATCH_EVENT;
   assign timer_ev = TIMER_WRAP_EVENT | TIMER_ZERO_EVENT;

   a_unused_lines_idle: assert property (
      IRQ_LINE[103] == 1'b0 && DMA_REQUEST[7:2] == 6'h0)
      else $error("unassigned line or request active");
   a_pin_request_follow: assert property (
      ready |-> DMA_REQUEST[1:0] == {2{$past(DMA_REQUEST_PIN)}})
      else $error("pin dma requests do not follow pin");
   a_tone_pair_match: assert property (IRQ_LINE[102] == DMA_REQUEST[40])
      else $error("tone line and tone dma request differ");
   a_tone_line_raise: assert property (
      ready && tone_ev ##1 !(WR && ADDR == 8'h1C) |-> ##1 IRQ_LINE[102])
      else $error("tone line not raised");
   a_timer_line_raise: assert property (
      ready && timer_ev != 4'h0 ##1 !(WR && ADDR == 8'h20)
      |-> ##1 &(IRQ_LINE[107:104] | ~$past(timer_ev, 2)))
      else $error("timer line not raised");
   a_cause_line_raise: assert property (
      ready && CAL_CAUSE_EVENT != 7'h0 ##1 !(WR && ADDR == 8'h18) |-> ##1 IRQ_LINE[101])
      else $error("calendar line not raised");
   a_tone_fall_clear: assert property (
      $fell(IRQ_LINE[102]) |-> $past(WR, 2) && $past(ADDR, 2) == 8'h1C)
      else $error("tone line fell without clear");
   a_read_data_idle: assert property (ready && !$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside read cycle");

   // main scenarios
   c_tone_raise: cover property ($rose(IRQ_LINE[102]));
   c_summary_irq: cover property ($rose(IRQ));
   c_last_channel: cover property ($rose(DMA_REQUEST[39]));
endmodule

bind request_router request_router_monitor request_router_monitor_i (.MCLK(MCLK), .RSTN(RSTN),
   .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .DMA_REQUEST_PIN(DMA_REQUEST_PIN),
   .CAL_CAUSE_EVENT(CAL_CAUSE_EVENT), .ZERO_AMPLITUDE_EVENT(ZERO_AMPLITUDE_EVENT),
   .TONE_PULSE_COUNT_EVENT(TONE_PULSE_COUNT_EVENT),
   .AMPLITUDE_MATCH_EVENT(AMPLITUDE_MATCH_EVENT), .TIMER_WRAP_EVENT(TIMER_WRAP_EVENT),
   .TIMER_ZERO_EVENT(TIMER_ZERO_EVENT), .IRQ_LINE(IRQ_LINE), .DMA_REQUEST(DMA_REQUEST),
   .IRQ(IRQ));

`default_nettype wire

// ---- request_routing_pkg.sv ----
// shared constants of the peripheral request router: register map,
// field layout, reset values, line and request numbering.
// assumes a 32-bit register port with word-aligned byte addresses.
`default_nettype none

package request_routing_pkg;

   // data and address widths of the register port
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_EXT_REQUEST = 8'h00;
   localparam logic [7:0] OFF_EXT_ENABLE = 8'h04;
   localparam logic [7:0] OFF_EXT_DMA_FLAG = 8'h08;
   localparam logic [7:0] OFF_EXT_DMA_ENABLE = 8'h0C;
   localparam logic [7:0] OFF_EXT_MODE_LO = 8'h10;
   localparam logic [7:0] OFF_EXT_MODE_HI = 8'h14;
   localparam logic [7:0] OFF_CAL_CAUSE = 8'h18;
   localparam logic [7:0] OFF_TONE_CONTROL = 8'h1C;
   localparam logic [7:0] OFF_TIMER_STATUS = 8'h20;
   localparam logic [7:0] OFF_EVT_STATUS = 8'h24;
   localparam logic [7:0] OFF_EVT_MASK = 8'h28;

   // source counts and field widths
   localparam int EXT_CHANNELS = 32;
   localparam int CAL_CAUSE_W = 7;
   localparam int TONE_FLAGS = 3;
   localparam int TIMERS = 4;
   localparam int EVT_W = 4;

   // tone control bit positions
   localparam int TONE_ZERO_BIT = 0;
   localparam int TONE_COUNT_BIT = 1;
   localparam int TONE_MATCH_BIT = 2;

   // timer status: wrap flags low nibble, zero flags next nibble
   localparam int TIMER_WRAP_LSB = 0;
   localparam int TIMER_ZERO_LSB = 4;

   // summary event bits
   localparam int EVT_EXT_BIT = 0;
   localparam int EVT_CAL_BIT = 1;
   localparam int EVT_TONE_BIT = 2;
   localparam int EVT_TIMER_BIT = 3;

   // detection condition codes, two bits per channel
   localparam logic [1:0] COND_LOW = 2'h0;
   localparam logic [1:0] COND_HIGH = 2'h1;
   localparam logic [1:0] COND_RISE = 2'h2;
   localparam logic [1:0] COND_FALL = 2'h3;

   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_MODE = 32'hAAAA_AAAA;

   // interrupt line numbering
   localparam int IRQ_FIRST = 70;
   localparam int IRQ_LAST = 107;
   localparam int IRQ_EXT_FIRST = 70;
   localparam int IRQ_CAL = 101;
   localparam int IRQ_TONE = 102;
   localparam int IRQ_UNUSED = 103;
   localparam int IRQ_TIMER_FIRST = 104;

   // dma request numbering
   localparam int DMA_LAST = 40;
   localparam int DMA_PIN_REQ0 = 0;
   localparam int DMA_PIN_REQ1 = 1;
   localparam int DMA_UNUSED_FIRST = 2;
   localparam int DMA_UNUSED_LAST = 7;
   localparam int DMA_EXT_FIRST = 8;
   localparam int DMA_TONE = 40;

endpackage

`default_nettype wire

// ---- request_sink_model.sv ----
// model of the processor interrupt controller and dma controller.
// assumes registered active-high lines from the router on one clock.
`default_nettype none

module irq_dma_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [107:70] irq_line,
   input wire logic [40:0] dma_req,
   output logic [107:70] seen_irq,
   output logic [40:0] seen_dma
);
   // sticky record of every line and request ever seen active
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seen_irq <= '0;
         seen_dma <= '0;
      end
      else
      begin
         seen_irq <= seen_irq | irq_line;
         seen_dma <= seen_dma | dma_req;
      end
   end
endmodule

`default_nettype wire

// ---- tb_request_router.sv ----
// self-checking bench for the request router with a sink model.
// assumes the register map and timings of the router package.
`default_nettype none

module tb_request_router;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 0, RSTN = 0, WR = 0, RD = 0, DMA_REQUEST_PIN = 0;
   logic [7:0] ADDR = 0;
   logic [31:0] WDATA = 0, EXT_PIN = 0, RDATA, rnd = 32'h0000_5241;
   logic [6:0] CAL_CAUSE_EVENT = 0;
   logic ZERO_AMPLITUDE_EVENT = 0, TONE_PULSE_COUNT_EVENT = 0, AMPLITUDE_MATCH_EVENT = 0, IRQ;
   logic [3:0] TIMER_WRAP_EVENT = 0, TIMER_ZERO_EVENT = 0;
   logic [107:70] IRQ_LINE, seen_irq;
   logic [40:0] DMA_REQUEST, seen_dma;
   int err_count = 0, check_count = 0, cycles = 0;
   logic idle;

   request_router request_router_i (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_PIN(EXT_PIN), .DMA_REQUEST_PIN(DMA_REQUEST_PIN),
      .CAL_CAUSE_EVENT(CAL_CAUSE_EVENT), .ZERO_AMPLITUDE_EVENT(ZERO_AMPLITUDE_EVENT),
      .TONE_PULSE_COUNT_EVENT(TONE_PULSE_COUNT_EVENT),
      .AMPLITUDE_MATCH_EVENT(AMPLITUDE_MATCH_EVENT), .TIMER_WRAP_EVENT(TIMER_WRAP_EVENT),
      .TIMER_ZERO_EVENT(TIMER_ZERO_EVENT), .IRQ_LINE(IRQ_LINE), .DMA_REQUEST(DMA_REQUEST),
      .IRQ(IRQ));
   irq_dma_sink irq_dma_sink_i (.clk(MCLK), .rst_n(RSTN), .irq_line(IRQ_LINE),
      .dma_req(DMA_REQUEST), .seen_irq(seen_irq), .seen_dma(seen_dma));

   // 50 MHz clock and hang guard
   always #10 MCLK = ~MCLK;
   always @(posedge MCLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         stop_test();
      end
   end

   // verdict and end of run
   task automatic stop_test();
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // expected {timer lines, tone line, calendar line} for a drawn event word
   function automatic logic [5:0] exp_lines(input logic [31:0] r);
      return {r[13:10] | r[17:14], |r[9:7], |r[6:0]};
   endfunction

   // expected channel lines: channel 0 has none, channel n is bit n-1
   function automatic logic [30:0] ext_line(input int n);
      return (n == 0) ? 31'h0 : 31'h1 << (n - 1);
   endfunction

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      @(negedge MCLK);
      chk(what, RDATA, exp);
   endtask

   task automatic settle();
      repeat (2) @(posedge MCLK);
      @(negedge MCLK);
   endtask

   // one-cycle events from a drawn word
   task automatic ev(input logic [31:0] r);
      @(posedge MCLK);
      {AMPLITUDE_MATCH_EVENT, TONE_PULSE_COUNT_EVENT, ZERO_AMPLITUDE_EVENT} <= r[9:7];
      CAL_CAUSE_EVENT <= r[6:0];
      TIMER_WRAP_EVENT <= r[13:10];
      TIMER_ZERO_EVENT <= r[17:14];
      @(posedge MCLK);
      {AMPLITUDE_MATCH_EVENT, TONE_PULSE_COUNT_EVENT, ZERO_AMPLITUDE_EVENT} <= 3'h0;
      CAL_CAUSE_EVENT <= 7'h0;
      TIMER_WRAP_EVENT <= 4'h0;
      TIMER_ZERO_EVENT <= 4'h0;
      settle();
   endtask

   task automatic pin_pulse(input logic [31:0] m);
      @(posedge MCLK);
      EXT_PIN <= m;
      @(posedge MCLK);
      EXT_PIN <= 32'h0000_0000;
      settle();
   endtask

   // main sequence
   initial
   begin
      repeat (5) @(posedge MCLK);
      RSTN <= 1'b1;
      repeat (3) @(posedge MCLK);
      rd("mode lo", 8'h10, request_routing_pkg::RST_MODE);
      rd("mode hi", 8'h14, request_routing_pkg::RST_MODE);
      rd("unmapped", 8'h3C, 32'h0000_0000);
      wr(8'h04, 32'hFFFF_FFFF);
      wr(8'h0C, 32'hFFFF_FFFF);
      // every detection condition on channel 3
      for (int code = 0; code < 4; code++)
      begin
         idle = (code == 0 || code == 3);
         @(posedge MCLK);
         EXT_PIN[3] <= idle;
         wr(8'h10, (request_routing_pkg::RST_MODE & ~32'h0000_00C0) | (32'(code) << 6));
         wr(8'h00, 32'hFFFF_FFFF);
         wr(8'h08, 32'hFFFF_FFFF);
         rd("quiet flags", 8'h00, 32'h0000_0000);
         @(posedge MCLK);
         EXT_PIN[3] <= !idle;
         settle();
         rd("cond flag", 8'h00, 32'h0000_0008);
         @(posedge MCLK);
         EXT_PIN[3] <= 1'b0;
      end
      wr(8'h10, request_routing_pkg::RST_MODE);
      wr(8'h00, 32'hFFFF_FFFF);
      wr(8'h08, 32'hFFFF_FFFF);
      // disabled channels set nothing
      wr(8'h04, 32'h0000_0000);
      wr(8'h0C, 32'h0000_0000);
      pin_pulse(32'hFFFF_FFFF);
      rd("off flags", 8'h00, 32'h0000_0000);
      rd("off dma", 8'h08, 32'h0000_0000);
      chk("off lines", IRQ_LINE[100:70], 31'h0);
      wr(8'h04, 32'hFFFF_FFFF);
      wr(8'h0C, 32'hFFFF_FFFF);
      // each channel alone, pin dma request drawn at random
      for (int n = 0; n < 32; n++)
      begin
         rnd = xs(rnd);
         DMA_REQUEST_PIN <= rnd[20];
         pin_pulse(32'h1 << n);
         chk("ext lines", IRQ_LINE[100:70], ext_line(n));
         chk("ext dma", DMA_REQUEST[39:8], 32'h1 << n);
         rd("ext flag", 8'h00, 32'h1 << n);
         rd("ext dma flag", 8'h08, 32'h1 << n);
         wr(8'h00, 32'h1 << n);
         wr(8'h08, 32'h1 << n);
      end
      // calendar, tone and timer events, all-ones first
      for (int i = 0; i < 12; i++)
      begin
         rnd = xs(rnd);
         if (i == 0)
            rnd = 32'h0003_FFFF;
         ev(rnd);
         chk("lines", {IRQ_LINE[107:104], IRQ_LINE[102:101]}, exp_lines(rnd));
         chk("tone dma", DMA_REQUEST[40], |rnd[9:7]);
         rd("cause", 8'h18, {25'h0, rnd[6:0]});
         rd("tone", 8'h1C, {29'h0, rnd[9:7]});
         rd("timer", 8'h20, {24'h0, rnd[17:14], rnd[13:10]});
         wr(8'h18, 32'hFFFF_FFFF);
         wr(8'h1C, 32'hFFFF_FFFF);
         wr(8'h20, 32'hFFFF_FFFF);
         settle();
         chk("cleared", {IRQ_LINE[107:104], IRQ_LINE[102:101], DMA_REQUEST[40]}, 7'h0);
      end
      // summary interrupt: mask, unmask, clear by read
      rd("summary", 8'h24, 32'h0000_000F);
      wr(8'h28, 32'h0000_0004);
      ev(32'h0000_0400);
      chk("masked irq", IRQ, 1'b0);
      wr(8'h28, 32'h0000_0008);
      settle();
      chk("unmasked irq", IRQ, 1'b1);
      rd("summary", 8'h24, 32'h0000_0008);
      settle();
      chk("irq cleared", IRQ, 1'b0);
      @(posedge MCLK);
      DMA_REQUEST_PIN <= 1'b1;
      settle();
      chk("pin dma", DMA_REQUEST[1:0], 2'b11);
      chk("seen irq", seen_irq, 38'h3D_FFFF_FFFF);
      chk("seen dma", seen_dma, 41'h1FF_FFFF_FF03);
      stop_test();
   end
endmodule

`default_nettype wire
